//--- dsc_pkg.sv
package dsc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int HOLD_S = 3;
  localparam int HOLD_CYC = HOLD_S * CLK_HZ;
  localparam int TMO_S = 10;
  localparam int TMO_CYC = TMO_S * CLK_HZ;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CFG_A = 8'h04;
  localparam logic [7:0] ADR_CFG_B = 8'h08;
  localparam logic [7:0] ADR_START_A = 8'h0C;
  localparam logic [7:0] ADR_END_A = 8'h10;
  localparam logic [7:0] ADR_OFFS_A = 8'h14;
  localparam logic [7:0] ADR_START_B = 8'h18;
  localparam logic [7:0] ADR_END_B = 8'h1C;
  localparam logic [7:0] ADR_OFFS_B = 8'h20;
  localparam logic [7:0] ADR_MFAC = 8'h24;
  localparam logic [7:0] ADR_DFAC = 8'h28;
  localparam logic [7:0] ADR_PFAC = 8'h2C;
  localparam logic [7:0] ADR_STATUS = 8'h30;
  localparam logic [7:0] ADR_VAL_A = 8'h34;
  localparam logic [7:0] ADR_VAL_B = 8'h38;
  localparam logic [7:0] ADR_VAL_C = 8'h3C;
  // ----------------------------------------
  // value limits and reset values
  // ----------------------------------------
  localparam logic signed [17:0] VAL_MAX = 18'sh1869F;
  localparam logic signed [17:0] MFAC_MAX = 18'sh02710;
  localparam logic signed [17:0] DFAC_MIN = 18'sh00001;
  localparam logic signed [17:0] FULL_CNT = 18'sh02710;
  localparam logic signed [17:0] LIVE_ZERO = 18'sh007D0;
  localparam logic signed [17:0] END_RST = 18'sh003E8;
  localparam logic signed [17:0] MFAC_RST = 18'sh003E8;
  localparam logic signed [17:0] DFAC_RST = 18'sh003E8;
  localparam logic [2:0] DP_MAX = 3'h5;
  localparam logic [2:0] DPA_RST = 3'h1;
  localparam logic [2:0] FILT_MAX = 3'h4;
  localparam int AVG_DEPTH = 16;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_SINGLE, MODE_DUAL, MODE_SUM, MODE_DIFF, MODE_RATIO, MODE_PROD
  } dsc_mode_t;
  typedef enum logic [1:0] {RNG_V10, RNG_I020, RNG_I420} dsc_range_t;
  typedef struct packed {
    dsc_range_t range;
    logic [2:0] dp;
    logic [2:0] filt;
    logic signed [17:0] start;
    logic signed [17:0] fin;
    logic signed [17:0] offs;
  } dsc_chan_t;
  typedef struct packed {
    logic signed [17:0] value;
    logic [2:0] dp;
    logic [1:0] view;
    logic err;
  } dsc_disp_t;
endpackage

//--- dsc_div.sv
`timescale 1ns/1ps
module dsc_div
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic signed [63:0] dvd_i,
  input wire logic signed [31:0] dvs_i,
  output logic done_o,
  output logic signed [63:0] quo_o
);
  typedef struct packed {
    logic busy;
    logic done;
    logic neg;
    logic [6:0] cnt;
    logic [63:0] acc;
    logic [63:0] rem;
    logic [31:0] dvs;
  } dsc_div_st_t;

  dsc_div_st_t st_ff;
  dsc_div_st_t nxt_st;

  // restoring division on magnitudes, sign fixed at the end; truncates toward zero
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (go_i && !st_ff.busy)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = DIV_STEPS;
      nxt_st.neg = dvd_i[63] ^ dvs_i[31];
      nxt_st.acc = dvd_i[63] ? 64'(-dvd_i) : dvd_i;
      nxt_st.rem = '0;
      nxt_st.dvs = dvs_i[31] ? 32'(-dvs_i) : dvs_i;
    end
    else if (st_ff.busy)
    begin
      nxt_st.rem = {st_ff.rem[62:0], st_ff.acc[63]};
      nxt_st.acc = {st_ff.acc[62:0], 1'b0};
      if (nxt_st.rem >= {32'h0, st_ff.dvs})
      begin
        nxt_st.rem = nxt_st.rem - {32'h0, st_ff.dvs};
        nxt_st.acc[0] = 1'b1;
      end
      nxt_st.cnt = st_ff.cnt - 7'h1;
      if (st_ff.cnt == 7'h1)
      begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        if (st_ff.neg)
          nxt_st.acc = 64'(-nxt_st.acc);
      end
    end
    if (rst_i)
      nxt_st = '0;
  end

  always_ff @(posedge clk_i)
    st_ff <= nxt_st;

  assign done_o = st_ff.done;
  assign quo_o = st_ff.acc;
endmodule

//--- dsc_avg.sv
`timescale 1ns/1ps
module dsc_avg
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic signed [15:0] raw_i,
  input wire logic [2:0] sel_i,
  output logic valid_o,
  output logic signed [15:0] avg_o
);
  typedef struct packed {
    logic [AVG_DEPTH-1:0][15:0] win;
    logic vld;
    logic [15:0] avg;
  } dsc_avg_st_t;

  dsc_avg_st_t st_ff;
  dsc_avg_st_t nxt_st;

  // window always shifts, so switching the depth averages real history at once
  always_comb
  begin
    logic signed [19:0] sum;
    sum = '0;
    nxt_st = st_ff;
    nxt_st.vld = 1'b0;
    if (valid_i)
    begin
      nxt_st.win = {st_ff.win[AVG_DEPTH-2:0], raw_i};
      for (int i = 0; i < AVG_DEPTH; i++)
        if (i < (1 << sel_i))
          sum = sum + 20'(signed'(nxt_st.win[i]));
      nxt_st.avg = 16'(sum >>> sel_i);
      nxt_st.vld = 1'b1;
    end
    if (rst_i)
      nxt_st = '0;
  end

  always_ff @(posedge clk_i)
    st_ff <= nxt_st;

  assign valid_o = st_ff.vld;
  assign avg_o = st_ff.avg;
endmodule

//--- dsc_top.sv
`timescale 1ns/1ps
module dsc_top
  import dsc_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int TIMEOUT_CYCLES = TMO_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [15:0] adc_a_i,
  input wire logic signed [15:0] adc_b_i,
  input wire logic adc_valid_i,
  input wire logic setup_done_i,
  input wire logic key_enter_i,
  input wire logic key_set_i,
  output logic menu_open_o,
  output logic [15:0] menu_visible_o,
  output dsc_disp_t disp_o
);
  typedef enum logic [2:0] {S_IDLE, S_SCA, S_WSC, S_CMB, S_WCB} dsc_calc_state_t;
  typedef struct packed {
    dsc_mode_t mode;
    logic tare;
    logic [2:0] cdp;
    dsc_chan_t [1:0] ch;
    logic signed [17:0] mfac;
    logic signed [17:0] dfac;
    logic signed [17:0] pfac;
    logic ack;
    logic [31:0] rdat;
    logic set_q;
    logic armed;
    logic menu;
    logic [31:0] hold;
    logic [31:0] idle;
    logic [1:0] view;
    dsc_calc_state_t cs;
    logic sel_b;
    logic step;
    logic go;
    logic signed [63:0] dvd;
    logic signed [31:0] dvs;
    logic signed [17:0] val_a;
    logic signed [17:0] val_b;
    logic signed [17:0] val_c;
    logic err;
    dsc_disp_t disp;
    logic [15:0] vis;
  } dsc_top_st_t;

  dsc_top_st_t st_ff;
  dsc_top_st_t nxt_st;
  logic [1:0][15:0] raw_w;
  logic [1:0][15:0] avg_w;
  logic [1:0] avg_vld;
  logic div_done;
  logic signed [63:0] quo;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic signed [17:0] sat(input logic signed [63:0] v,
                                             input logic signed [17:0] lo,
                                             input logic signed [17:0] hi);
    if (v > 64'(hi))
      sat = hi;
    else if (v < 64'(lo))
      sat = lo;
    else
      sat = v[17:0];
  endfunction

  function automatic logic [31:0] sx(input logic signed [17:0] v);
    sx = {{14{v[17]}}, v};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
  endfunction

  function automatic logic signed [17:0] wval(input logic signed [17:0] old,
                                              input logic signed [17:0] lo,
                                              input logic signed [17:0] hi,
                                              input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = merge(sx(old), d, s);
    wval = sat(64'(signed'(m)), lo, hi);
  endfunction

  function automatic logic [31:0] cfg_word(input dsc_chan_t c);
    cfg_word = {24'h0, c.filt, c.dp, c.range};
  endfunction

  function automatic dsc_chan_t cfg_wr(input dsc_chan_t c, input logic [31:0] w);
    cfg_wr = c;
    if (w[1:0] != 2'h3)
      cfg_wr.range = dsc_range_t'(w[1:0]);
    cfg_wr.dp = (w[4:2] > DP_MAX) ? DP_MAX : w[4:2];
    cfg_wr.filt = (w[7:5] > FILT_MAX) ? FILT_MAX : w[7:5];
  endfunction

  // live-zero range maps 2000..10000 counts onto 0..10000
  function automatic logic signed [19:0] norm(input logic signed [15:0] raw,
                                              input dsc_range_t r);
    logic signed [19:0] x;
    x = 20'(raw);
    if (r == RNG_I420)
      norm = 20'(((x - 20'(LIVE_ZERO)) * 20'sh00005) >>> 2);
    else
      norm = x;
  endfunction

  // ----------------------------------------
  // per-channel averaging and shared divider
  // ----------------------------------------
  assign raw_w = {adc_b_i, adc_a_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    dsc_avg u_avg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .valid_i(adc_valid_i),
      .raw_i(raw_w[g]),
      .sel_i(st_ff.ch[g].filt),
      .valid_o(avg_vld[g]),
      .avg_o(avg_w[g])
    );
  end

  dsc_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(st_ff.go),
    .dvd_i(st_ff.dvd),
    .dvs_i(st_ff.dvs),
    .done_o(div_done),
    .quo_o(quo)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    dsc_chan_t c;
    logic signed [63:0] a;
    logic signed [63:0] b;
    logic signed [63:0] v;
    c = st_ff.ch[st_ff.sel_b];
    a = 64'(st_ff.val_a);
    b = 64'(st_ff.val_b);
    v = '0;
    nxt_st = st_ff;
    nxt_st.go = 1'b0;
    nxt_st.set_q = key_set_i;

    // register bus: one-cycle ack, unmapped reads zero, unmapped writes dropped
    nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
    if (wb_cyc_i && wb_stb_i && !st_ff.ack)
    begin
      if (wb_adr_i == ADR_CTRL)
        nxt_st.rdat = {25'h0, st_ff.cdp, st_ff.tare, st_ff.mode};
      else if (wb_adr_i == ADR_CFG_A)
        nxt_st.rdat = cfg_word(st_ff.ch[0]);
      else if (wb_adr_i == ADR_CFG_B)
        nxt_st.rdat = cfg_word(st_ff.ch[1]);
      else if (wb_adr_i == ADR_START_A)
        nxt_st.rdat = sx(st_ff.ch[0].start);
      else if (wb_adr_i == ADR_END_A)
        nxt_st.rdat = sx(st_ff.ch[0].fin);
      else if (wb_adr_i == ADR_OFFS_A)
        nxt_st.rdat = sx(st_ff.ch[0].offs);
      else if (wb_adr_i == ADR_START_B)
        nxt_st.rdat = sx(st_ff.ch[1].start);
      else if (wb_adr_i == ADR_END_B)
        nxt_st.rdat = sx(st_ff.ch[1].fin);
      else if (wb_adr_i == ADR_OFFS_B)
        nxt_st.rdat = sx(st_ff.ch[1].offs);
      else if (wb_adr_i == ADR_MFAC)
        nxt_st.rdat = sx(st_ff.mfac);
      else if (wb_adr_i == ADR_DFAC)
        nxt_st.rdat = sx(st_ff.dfac);
      else if (wb_adr_i == ADR_PFAC)
        nxt_st.rdat = sx(st_ff.pfac);
      else if (wb_adr_i == ADR_STATUS)
        nxt_st.rdat = {st_ff.vis, 12'h0, st_ff.view, st_ff.err, st_ff.menu};
      else if (wb_adr_i == ADR_VAL_A)
        nxt_st.rdat = sx(st_ff.val_a);
      else if (wb_adr_i == ADR_VAL_B)
        nxt_st.rdat = sx(st_ff.val_b);
      else if (wb_adr_i == ADR_VAL_C)
        nxt_st.rdat = sx(st_ff.val_c);
      else
        nxt_st.rdat = '0;
      if (wb_we_i)
      begin
        if (wb_adr_i == ADR_CTRL && wb_sel_i[0])
        begin
          if (wb_dat_i[2:0] <= 3'h5)
            nxt_st.mode = dsc_mode_t'(wb_dat_i[2:0]);
          nxt_st.tare = wb_dat_i[3];
          nxt_st.cdp = (wb_dat_i[6:4] > DP_MAX) ? DP_MAX : wb_dat_i[6:4];
        end
        else if (wb_adr_i == ADR_CFG_A && wb_sel_i[0])
          nxt_st.ch[0] = cfg_wr(st_ff.ch[0], wb_dat_i);
        else if (wb_adr_i == ADR_CFG_B && wb_sel_i[0])
          nxt_st.ch[1] = cfg_wr(st_ff.ch[1], wb_dat_i);
        else if (wb_adr_i == ADR_START_A)
          nxt_st.ch[0].start = wval(st_ff.ch[0].start, -VAL_MAX, VAL_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_END_A)
          nxt_st.ch[0].fin = wval(st_ff.ch[0].fin, -VAL_MAX, VAL_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_OFFS_A)
          nxt_st.ch[0].offs = wval(st_ff.ch[0].offs, -VAL_MAX, VAL_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_START_B)
          nxt_st.ch[1].start = wval(st_ff.ch[1].start, -VAL_MAX, VAL_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_END_B)
          nxt_st.ch[1].fin = wval(st_ff.ch[1].fin, -VAL_MAX, VAL_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_OFFS_B)
          nxt_st.ch[1].offs = wval(st_ff.ch[1].offs, -VAL_MAX, VAL_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_MFAC)
          nxt_st.mfac = wval(st_ff.mfac, -MFAC_MAX, MFAC_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_DFAC)
          nxt_st.dfac = wval(st_ff.dfac, DFAC_MIN, VAL_MAX, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_PFAC)
          nxt_st.pfac = wval(st_ff.pfac, -VAL_MAX, VAL_MAX, wb_dat_i, wb_sel_i);
      end
    end

    // menu: a hold must be released before it can count again
    if (!key_enter_i)
    begin
      nxt_st.hold = '0;
      nxt_st.armed = 1'b1;
    end
    else if (st_ff.armed)
    begin
      if (st_ff.hold == 32'(HOLD_CYCLES - 1))
      begin
        nxt_st.hold = '0;
        nxt_st.armed = 1'b0;
        if (st_ff.menu)
          nxt_st.menu = 1'b0;
        else if (setup_done_i)
          nxt_st.menu = 1'b1;
      end
      else
        nxt_st.hold = st_ff.hold + 32'h1;
    end
    if (!st_ff.menu || key_enter_i || key_set_i)
      nxt_st.idle = '0;
    else if (st_ff.idle == 32'(TIMEOUT_CYCLES - 1))
    begin
      nxt_st.idle = '0;
      nxt_st.menu = 1'b0;
    end
    else
      nxt_st.idle = st_ff.idle + 32'h1;

    // visible parameters: range, start, end, dp, filter, offset (only with tare) per channel; channel B not in single mode
    nxt_st.vis = {10'h0, st_ff.tare, 5'h1F};
    if (st_ff.mode != MODE_SINGLE)
      nxt_st.vis[11:6] = nxt_st.vis[5:0];
    if (st_ff.mode >= MODE_SUM)
      nxt_st.vis[15:12] = 4'hF;

    // view selection by the set key
    if (key_set_i && !st_ff.set_q && !st_ff.menu)
    begin
      if (st_ff.mode == MODE_DUAL)
        nxt_st.view = (st_ff.view == 2'h0) ? 2'h1 : 2'h0;
      else if (st_ff.mode >= MODE_SUM)
        nxt_st.view = (st_ff.view == 2'h2) ? 2'h0 : st_ff.view + 2'h1;
    end
    if (st_ff.mode == MODE_SINGLE || (st_ff.mode == MODE_DUAL && st_ff.view == 2'h2))
      nxt_st.view = 2'h0;

    // calculation sequence; samples arriving while busy are skipped
    case (st_ff.cs)
      S_IDLE:
        if (avg_vld[0])
        begin
          nxt_st.sel_b = 1'b0;
          nxt_st.cs = S_SCA;
        end
      S_SCA:
      begin
        v = 64'(norm(avg_w[st_ff.sel_b], c.range));
        nxt_st.dvd = (64'(c.fin) - 64'(c.start)) * v;
        nxt_st.dvs = 32'(FULL_CNT);
        nxt_st.go = 1'b1;
        nxt_st.cs = S_WSC;
      end
      S_WSC:
        if (div_done)
        begin
          v = 64'(c.start) + quo + (st_ff.tare ? 64'(c.offs) : 64'h0);
          if (st_ff.sel_b)
            nxt_st.val_b = sat(v, -VAL_MAX, VAL_MAX);
          else
            nxt_st.val_a = sat(v, -VAL_MAX, VAL_MAX);
          if (!st_ff.sel_b && st_ff.mode != MODE_SINGLE)
          begin
            nxt_st.sel_b = 1'b1;
            nxt_st.cs = S_SCA;
          end
          else if (st_ff.mode >= MODE_SUM)
            nxt_st.cs = S_CMB;
          else
            nxt_st.cs = S_IDLE;
        end
      S_CMB:
      begin
        nxt_st.err = 1'b0;
        nxt_st.step = 1'b0;
        nxt_st.dvs = 32'(st_ff.dfac);
        nxt_st.go = 1'b1;
        nxt_st.cs = S_WCB;
        case (st_ff.mode)
          MODE_SUM:
            v = a + b;
          MODE_DIFF:
            v = a - b;
          MODE_PROD:
            v = a * b;
          default:
            v = a;
        endcase
        nxt_st.dvd = v * 64'(st_ff.mfac);
        if (st_ff.mode == MODE_RATIO)
        begin
          nxt_st.step = 1'b1;
          nxt_st.dvs = 32'(st_ff.val_b);
          if (st_ff.val_b == 18'sh00000)
          begin
            nxt_st.err = 1'b1;
            nxt_st.go = 1'b0;
            nxt_st.cs = S_IDLE;
          end
        end
      end
      S_WCB:
        if (div_done)
        begin
          if (st_ff.step)
          begin
            nxt_st.step = 1'b0;
            nxt_st.dvd = quo;
            nxt_st.dvs = 32'(st_ff.dfac);
            nxt_st.go = 1'b1;
          end
          else
          begin
            nxt_st.val_c = sat(quo + 64'(st_ff.pfac), -VAL_MAX, VAL_MAX);
            nxt_st.cs = S_IDLE;
          end
        end
      default:
        nxt_st.cs = S_IDLE;
    endcase

    // display word follows the view
    nxt_st.disp.view = st_ff.view;
    nxt_st.disp.err = 1'b0;
    if (st_ff.view == 2'h0)
    begin
      nxt_st.disp.value = st_ff.val_a;
      nxt_st.disp.dp = st_ff.ch[0].dp;
    end
    else if (st_ff.view == 2'h1)
    begin
      nxt_st.disp.value = st_ff.val_b;
      nxt_st.disp.dp = st_ff.ch[1].dp;
    end
    else
    begin
      nxt_st.disp.value = st_ff.err ? 18'sh00000 : st_ff.val_c;
      nxt_st.disp.dp = st_ff.cdp;
      nxt_st.disp.err = st_ff.err;
    end

    if (rst_i)
    begin
      nxt_st = '0;
      nxt_st.mode = MODE_SINGLE;
      nxt_st.ch[0].fin = END_RST;
      nxt_st.ch[1].fin = END_RST;
      nxt_st.ch[0].dp = DPA_RST;
      nxt_st.mfac = MFAC_RST;
      nxt_st.dfac = DFAC_RST;
    end
  end

  always_ff @(posedge clk_i)
    st_ff <= nxt_st;

  assign wb_dat_o = st_ff.rdat;
  assign wb_ack_o = st_ff.ack;
  assign menu_open_o = st_ff.menu;
  assign menu_visible_o = st_ff.vis;
  assign disp_o = st_ff.disp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  menu_open_a : assert property ($rose(st_ff.menu) |-> $past(st_ff.hold) == 32'(HOLD_CYCLES - 1))
    else $error("menu opened without full hold");
  menu_leave_a : assert property ($fell(st_ff.menu) |-> $past(st_ff.hold) == 32'(HOLD_CYCLES - 1)
    || $past(st_ff.idle) == 32'(TIMEOUT_CYCLES - 1))
    else $error("menu closed without hold or timeout");
  vis_single_a : assert property (st_ff.mode == MODE_SINGLE |=> st_ff.vis[15:6] == 10'h0)
    else $error("channel B items visible in single mode");
  dual_toggle_a : assert property (st_ff.mode == MODE_DUAL && key_set_i && !st_ff.set_q
    && !st_ff.menu && st_ff.view == 2'h0 |=> st_ff.view == 2'h1 ##1 disp_o.view == 2'h1)
    else $error("set key did not toggle dual view");
  dfac_range_a : assert property (st_ff.dfac >= DFAC_MIN && st_ff.dfac <= VAL_MAX)
    else $error("divisor out of range");
  disp_sat_a : assert property (disp_o.value <= VAL_MAX && disp_o.value >= -VAL_MAX)
    else $error("display value not saturated");
  ratio_err_a : assert property (st_ff.cs == S_CMB && st_ff.mode == MODE_RATIO
    && st_ff.val_b == 18'sh00000 |=> st_ff.err && st_ff.cs == S_IDLE)
    else $error("ratio by zero not flagged");
  wb_ack_a : assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
endmodule

//--- dsc_pad.sv
`timescale 1ns/1ps
module dsc_pad
  import dsc_pkg::*;
(
  input wire logic clk_i,
  output logic key_enter_o,
  output logic key_set_o
);
  initial
  begin
    key_enter_o = 1'b0;
    key_set_o = 1'b0;
  end
  // keys move just after an edge, like a synchronised operator
  task automatic hold_enter(input int n);
    @(posedge clk_i);
    key_enter_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    key_enter_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic tap_set();
    @(posedge clk_i);
    key_set_o <= 1'b1;
    @(posedge clk_i);
    key_set_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top import dsc_pkg::*;;
  logic clk_i, rst_i, cyc, stb, we, ack, av, sd, ke, ks, mo;
  logic [7:0] adr;
  logic [3:0] sel;
  int v;
  logic [31:0] wd, rd, rv;
  logic [15:0] vis;
  logic signed [15:0] ra, rb;
  longint a, b;
  dsc_disp_t disp;
  int err_count, check_count;
  dsc_top #(.HOLD_CYCLES(20), .TIMEOUT_CYCLES(50)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rv), .wb_ack_o(ack), .adc_a_i(ra), .adc_b_i(rb),
    .adc_valid_i(av), .setup_done_i(sd), .key_enter_i(ke), .key_set_i(ks),
    .menu_open_o(mo), .menu_visible_o(vis), .disp_o(disp));
  dsc_pad pad (.clk_i(clk_i), .key_enter_o(ke), .key_set_o(ks));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wd <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_count++;
      print_verdict();
    end
    rd = rv;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // spacing leaves room for the longest calculation, ratio with four divisions
  task automatic pulse(input logic [15:0] x, input logic [15:0] y);
    @(posedge clk_i);
    av <= 1'b1;
    ra <= x;
    rb <= y;
    @(posedge clk_i);
    av <= 1'b0;
    repeat (300) @(posedge clk_i);
  endtask
  function automatic logic [15:0] rnd();
    return 16'($urandom_range(20000)) - 16'h2710;
  endfunction
  function automatic longint sat(longint v);
    return v > 99999 ? 99999 : (v < -99999 ? -99999 : v);
  endfunction
  // mfac and dfac stay at 1000, pfac at 100; only ratio keeps its split division
  function automatic longint ex_c(int m, longint x, longint y);
    if (m == 4)
      return sat(x * 1000 / y / 1000 + 100);
    return sat((m == 2 ? x + y : (m == 3 ? x - y : x * y)) + 100);
  endfunction
  // display word: err, dp, value for the given view
  function automatic logic [31:0] ex_d(int m, int w, longint x, longint y);
    logic z;
    longint e;
    z = w == 2 && m == 4 && y == 0;
    e = w == 0 ? x : (w == 1 ? y : (z ? 0 : ex_c(m, x, y)));
    return {10'h0, z, w == 0 ? 3'h1 : 3'h0, 18'(e)};
  endfunction
  initial
  begin
    {rst_i, sd} = 2'h3;
    {cyc, stb, we, av, adr, wd, ra, rb} = '0;
    sel = 4'hF;
    err_count = 0;
    check_count = 0;
    void'($urandom(32'h8c588631));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // ----------------------------------------
    // defaults and clamps
    // ----------------------------------------
    wb(0, ADR_CTRL, 0);
    chk(rd, 32'h0);
    wb(0, ADR_CFG_A, 0);
    chk(rd, 32'h4);
    wb(0, ADR_END_A, 0);
    chk(rd, 32'h3E8);
    wb(0, 8'h40, 0);
    chk(rd, 32'h0);
    chk(32'(vis), 32'h1F);
    wb(1, ADR_DFAC, 0);
    wb(0, ADR_DFAC, 0);
    chk(rd, 32'h1);
    wb(1, ADR_DFAC, 32'h3E8);
    wb(1, ADR_MFAC, 32'h4E20);
    wb(0, ADR_MFAC, 0);
    chk(rd, 32'h2710);
    wb(1, ADR_MFAC, 32'h3E8);
    // ----------------------------------------
    // menu keys
    // ----------------------------------------
    pad.hold_enter(10);
    chk(32'(mo), 32'h0);
    sd <= 1'b0;
    pad.hold_enter(25);
    chk(32'(mo), 32'h0);
    sd <= 1'b1;
    pad.hold_enter(25);
    chk(32'(mo), 32'h1);
    pad.hold_enter(25);
    chk(32'(mo), 32'h0);
    pad.hold_enter(25);
    chk(32'(mo), 32'h1);
    repeat (60) @(posedge clk_i);
    chk(32'(mo), 32'h0);
    // ----------------------------------------
    // modes, scaling and views
    // ----------------------------------------
    wb(1, ADR_PFAC, 32'h64);
    for (int m = 0; m < 6; m++)
    begin
      wb(1, ADR_CTRL, 32'(m));
      for (int k = 0; k < 4; k++)
      begin
        pulse(rnd(), (m == 4 && k == 0) ? 16'h0 : rnd());
        a = ra / 10;
        b = rb / 10;
        wb(0, ADR_VAL_A, 0);
        chk(rd, 32'(a));
        wb(0, ADR_VAL_B, 0);
        chk(rd, m == 0 ? 32'h0 : 32'(b));
        wb(0, (m == 4 && b == 0) ? ADR_STATUS : ADR_VAL_C, 0);
        if (m == 4 && b == 0)
          chk(32'(rd[1]), 32'h1);
        else if (m > 1)
          chk(rd, 32'(ex_c(m, a, b)));
      end
      chk(32'(vis), m == 0 ? 32'h1F : (m == 1 ? 32'h7DF : 32'hF7DF));
      for (int k = 1; k <= 6; k++)
      begin
        v = m == 0 ? 0 : (m == 1 ? k % 2 : k % 3);
        pad.tap_set();
        chk(32'(disp.view), 32'(v));
        chk({10'h0, disp.err, disp.dp, disp.value}, ex_d(m, v, a, b));
      end
    end
    wb(1, ADR_CTRL, 32'h9);
    repeat (2) @(posedge clk_i);
    chk(32'(vis), 32'hFFF);
    sel <= 4'h1;
    wb(1, ADR_END_A, 32'hFFFFFF00);
    sel <= 4'hF;
    wb(0, ADR_END_A, 0);
    chk(rd, 32'h300);
    wb(1, ADR_END_A, 32'h3E8);
    wb(1, ADR_OFFS_A, 32'h5);
    wb(1, ADR_CFG_A, 32'h26);
    pulse(rnd(), rnd());
    a = ra;
    pulse(rnd(), rnd());
    a = ((((a + ra) >>> 1) - 2000) * 5 >>> 2) / 10 + 5;
    wb(0, ADR_VAL_A, 0);
    chk(rd, 32'(a));
    print_verdict();
  end
endmodule
